/* rtl/dsoc_pkg.sv */
package dsoc_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] DSOC_CTRL_OFFS = 8'h00;
   localparam logic [7:0] DSOC_STAT_OFFS = 8'h04;
   localparam logic [7:0] DSOC_DATA_OFFS = 8'h08;
   localparam logic [7:0] DSOC_LOCKCNT_OFFS = 8'h0C;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int DSOC_CTRL_PWR_BIT = 0;
   localparam int DSOC_CTRL_OEN_BIT = 1;
   localparam int DSOC_CTRL_EDGE_BIT = 2;
   localparam logic [2:0] DSOC_CTRL_RST = 3'h0;
   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int DSOC_STAT_LOCKN_BIT = 0;
   localparam int DSOC_STAT_EMPTY_BIT = 1;
   localparam int DSOC_STAT_FULL_BIT = 2;
   localparam int DSOC_STAT_OVF_BIT = 3;
   // ----------------------------------------
   // widths and timing
   // ----------------------------------------
   localparam int DSOC_WORD_W = 10;
   localparam int DSOC_FRAME_BITS = 12;
   localparam int DSOC_FIFO_DEPTH = 8;
   localparam int DSOC_LOCK_FRAMES = 4;
   localparam int DSOC_CLK_NS = 50;
   typedef enum logic [2:0] {
      DSOC_ST_SLEEP = 3'b001,
      DSOC_ST_ACQ = 3'b010,
      DSOC_ST_LOCK = 3'b100
   } dsoc_state_t;
endpackage

/* rtl/dsoc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dsoc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dsoc_fifo_st_t;
   dsoc_fifo_st_t s_r;
   dsoc_fifo_st_t s_nxt;
   logic push;
   logic pop;
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be a power of two");
   end
   assign in_ready_out = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_out = (s_r.cnt != '0);
   assign out_data_out = s_r.mem[s_r.rp];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data_in;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush_in) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

/* rtl/dsoc_top.sv */
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dsoc_top
   import dsoc_pkg::*;
#(
   parameter int WORD_W = dsoc_pkg::DSOC_WORD_W,
   parameter int FIFO_DEPTH = dsoc_pkg::DSOC_FIFO_DEPTH,
   parameter int LOCK_FRAMES = dsoc_pkg::DSOC_LOCK_FRAMES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic serial_input_pos_in,
   input wire logic serial_input_neg_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [WORD_W-1:0] recovered_data_out,
   output logic [WORD_W-1:0] recovered_data_oe_n_out,
   output logic recovered_clock_out,
   output logic recovered_clock_oe_n_out,
   output logic lock_n_out,
   output logic lock_n_oe_n_out
);
   import dsoc_pkg::*;
   localparam int FB = DSOC_FRAME_BITS;
   if (WORD_W != FB - 2) begin : g_bad_width
      $error("word width must be frame bits minus two");
   end
   if (LOCK_FRAMES < 1 || LOCK_FRAMES > 15) begin : g_bad_lock
      $error("lock frames out of range");
   end
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      dsoc_state_t st;
      logic [FB-1:0] shreg;
      logic [3:0] bitcnt;
      logic [3:0] good;
      logic [WORD_W-1:0] dout;
      logic rclk;
      logic power_n;
      logic out_en;
      logic edge_sel;
      logic ovf;
      logic [15:0] lock_cnt;
      logic [31:0] prdata;
   } dsoc_st_t;
   dsoc_st_t s_r;
   dsoc_st_t s_nxt;
   logic ser_bit;
   logic ser_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;
   logic fifo_pop;
   logic fifo_push;
   logic [WORD_W-1:0] frame_word;
   logic frame_ok;
   logic locked;
   logic drive_ok;
   logic acc;
   logic rd_fire;
   logic strobe_edge;
   logic flush;
   logic [FB-1:0] frame_next;
   logic wr_fire;
   logic wait_r;
   logic wait_nxt;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction
   // serial line arrives as a differential pair, each leg synchronised
   assign ser_bit = s_r.sync2[0] & ~s_r.sync2[1];
   assign ser_valid = s_r.sync2[0] ^ s_r.sync2[1];
   // frame: start bit 1, ten data bits, stop bit 0 gives the embedded clock edge
   // judge the frame with the bit arriving now, else the check lags one bit
   assign frame_next = {s_r.shreg[FB-2:0], ser_bit};
   assign frame_ok = frame_next[FB-1] && !frame_next[0];
   assign frame_word = frame_next[FB-2:1];
   assign locked = (s_r.st == DSOC_ST_LOCK);
   // data path only opens when powered, enabled and locked
   assign drive_ok = s_r.power_n && s_r.out_en && locked;
   // rclk toggles every cycle, so one full period spans two clocks
   assign strobe_edge = s_r.edge_sel ? !s_r.rclk : s_r.rclk;
   assign fifo_pop = drive_ok && strobe_edge && fifo_out_valid;
   assign fifo_push = locked && ser_valid && frame_ok && s_r.bitcnt == 4'(FB - 1);
   assign flush = !locked;
   assign acc = psel_in && penable_in;
   assign rd_fire = acc && !pwrite_in;
   // a write lands only at the edge where pready is seen high
   assign wr_fire = acc && wait_r && pwrite_in;
   // ----------------------------------------
   // data buffer
   // ----------------------------------------
   // a full buffer drops words and flags overflow: the line cannot be stalled
   dsoc_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flush_in(flush),
      .in_valid_in(fifo_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(frame_word),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_pop),
      .out_data_out(fifo_out_data)
   );
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = {serial_input_neg_in, serial_input_pos_in};
      s_nxt.sync2 = s_r.sync1;
      if (ser_valid) begin
         s_nxt.shreg = frame_next;
         s_nxt.bitcnt = (s_r.bitcnt == 4'(FB - 1)) ? 4'h0 : s_r.bitcnt + 4'h1;
      end
      unique case (s_r.st)
         DSOC_ST_SLEEP: begin
            s_nxt.good = 4'h0;
            if (s_r.power_n) begin
               s_nxt.st = DSOC_ST_ACQ;
            end
         end
         DSOC_ST_ACQ: begin
            // hunt: slide the frame boundary until start and stop line up
            if (ser_valid && s_r.bitcnt == 4'(FB - 1)) begin
               if (frame_ok) begin
                  s_nxt.good = s_r.good + 4'h1;
                  if (s_r.good == 4'(LOCK_FRAMES - 1)) begin
                     s_nxt.st = DSOC_ST_LOCK;
                     s_nxt.lock_cnt = s_r.lock_cnt + 16'h0001;
                  end
               end else begin
                  s_nxt.good = 4'h0;
                  // stay at the boundary count so the next bit is judged again
                  s_nxt.bitcnt = 4'(FB - 1);
               end
            end
         end
         DSOC_ST_LOCK: begin
            // one bad frame drops lock; resync starts from scratch
            if (ser_valid && s_r.bitcnt == 4'(FB - 1) && !frame_ok) begin
               s_nxt.st = DSOC_ST_ACQ;
               s_nxt.good = 4'h0;
               s_nxt.bitcnt = 4'h0;
            end
         end
         default: s_nxt.st = DSOC_ST_SLEEP;
      endcase
      if (!s_r.power_n) begin
         s_nxt.st = DSOC_ST_SLEEP;
      end
      if (fifo_push && !fifo_in_ready) begin
         s_nxt.ovf = 1'b1;
      end
      if (fifo_pop) begin
         s_nxt.dout = fifo_out_data;
      end
      if (wr_fire) begin
         if (hit(paddr_in, DSOC_CTRL_OFFS)) begin
            s_nxt.power_n = pwdata_in[DSOC_CTRL_PWR_BIT];
            s_nxt.out_en = pwdata_in[DSOC_CTRL_OEN_BIT];
            s_nxt.edge_sel = pwdata_in[DSOC_CTRL_EDGE_BIT];
         end
         // set wins over clear
         if (hit(paddr_in, DSOC_STAT_OFFS) && pwdata_in[DSOC_STAT_OVF_BIT] &&
             !(fifo_push && !fifo_in_ready)) begin
            s_nxt.ovf = 1'b0;
         end
      end
      // recovered clock toggles every cycle while driven; parked low as the pins float
      if (s_nxt.power_n && s_nxt.out_en && s_nxt.st == DSOC_ST_LOCK) begin
         s_nxt.rclk = !s_r.rclk;
      end else begin
         s_nxt.rclk = 1'b0;
      end
      s_nxt.prdata = 32'h0000_0000;
      if (rd_fire) begin
         if (hit(paddr_in, DSOC_CTRL_OFFS)) begin
            s_nxt.prdata[DSOC_CTRL_PWR_BIT] = s_r.power_n;
            s_nxt.prdata[DSOC_CTRL_OEN_BIT] = s_r.out_en;
            s_nxt.prdata[DSOC_CTRL_EDGE_BIT] = s_r.edge_sel;
         end else if (hit(paddr_in, DSOC_STAT_OFFS)) begin
            s_nxt.prdata[DSOC_STAT_LOCKN_BIT] = !locked;
            s_nxt.prdata[DSOC_STAT_EMPTY_BIT] = !fifo_out_valid;
            s_nxt.prdata[DSOC_STAT_FULL_BIT] = !fifo_in_ready;
            s_nxt.prdata[DSOC_STAT_OVF_BIT] = s_r.ovf;
         end else if (hit(paddr_in, DSOC_DATA_OFFS)) begin
            s_nxt.prdata[WORD_W-1:0] = s_r.dout;
         end else if (hit(paddr_in, DSOC_LOCKCNT_OFFS)) begin
            s_nxt.prdata[15:0] = s_r.lock_cnt;
         end
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
         s_r.st <= DSOC_ST_SLEEP;
      end else begin
         s_r <= s_nxt;
      end
   end
   // ----------------------------------------
   // apb answer
   // ----------------------------------------
   // one wait state: read data is registered at the first access cycle
   assign wait_nxt = acc && !wait_r;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= wait_nxt;
      end
   end
   assign pready_out = acc && wait_r;
   assign pslverr_out = pready_out && !(hit(paddr_in, DSOC_CTRL_OFFS) ||
      hit(paddr_in, DSOC_STAT_OFFS) || hit(paddr_in, DSOC_DATA_OFFS) ||
      hit(paddr_in, DSOC_LOCKCNT_OFFS));
   assign prdata_out = s_r.prdata;
   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign recovered_data_out = s_r.dout;
   assign recovered_data_oe_n_out = {WORD_W{!drive_ok}};
   assign recovered_clock_out = s_r.rclk;
   assign recovered_clock_oe_n_out = !drive_ok;
   assign lock_n_out = !locked;
   assign lock_n_oe_n_out = !s_r.power_n;
endmodule
`default_nettype wire

/* sim/dsoc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dsoc_monitor #(
   parameter int WORD_W = 10
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [WORD_W-1:0] recovered_data_out,
   input wire logic [WORD_W-1:0] recovered_data_oe_n_out,
   input wire logic recovered_clock_out,
   input wire logic recovered_clock_oe_n_out,
   input wire logic lock_n_out,
   input wire logic lock_n_oe_n_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_unlock_data_float: assert property (lock_n_out |-> &recovered_data_oe_n_out)
      else $error("data driven while unlocked");
   a_unlock_clk_float: assert property (lock_n_out |-> recovered_clock_oe_n_out)
      else $error("clock driven while unlocked");
   a_oe_bits_same: assert property (&recovered_data_oe_n_out || ~|recovered_data_oe_n_out)
      else $error("data enables split");
   a_clk_oe_pair: assert property (recovered_clock_oe_n_out == recovered_data_oe_n_out[0])
      else $error("clock and data enables differ");
   a_sleep_all_float: assert property (lock_n_oe_n_out |-> recovered_clock_oe_n_out)
      else $error("output driven while asleep");
   a_rclk_runs: assert property (!recovered_clock_oe_n_out [*2] |-> $changed(recovered_clock_out))
      else $error("clock stalled");
   a_rclk_quiet: assert property (recovered_clock_oe_n_out |-> !recovered_clock_out)
      else $error("floated clock not low");
   a_data_on_strobe: assert property (!recovered_data_oe_n_out[0] && $past(!recovered_data_oe_n_out[0])
      && $changed(recovered_data_out) |-> $changed(recovered_clock_out))
      else $error("data moved off clock edge");
   a_apb_one_wait: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
      else $error("wait state count wrong");
   c_lock: cover property ($fell(lock_n_out));
   c_slverr: cover property (pslverr_out);
   c_word: cover property (!recovered_data_oe_n_out[0] ##1 $changed(recovered_data_out));
endmodule
`default_nettype wire

/* sim/dsoc_ser_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsoc_ser_model (
   input wire logic clk_in,
   output logic pos_out = 1'b0,
   output logic neg_out = 1'b0
);
   logic q[$];
   logic idle_r = 1'b0;
   // frame: start 1, word msb first, stop 0
   function automatic void send(input logic [9:0] w);
      q.push_back(1'b1);
      for (int i = 9; i >= 0; i--) q.push_back(w[i]);
      q.push_back(1'b0);
   endfunction
   // idle legs equal and toggling, so no stale bit reads as valid
   always @(posedge clk_in) begin
      idle_r <= ~idle_r;
      pos_out <= (q.size() > 0) ? q[0] : idle_r;
      neg_out <= (q.size() > 0) ? ~q[0] : idle_r;
      if (q.size() > 0) void'(q.pop_front());
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("Error %0t got %h expected %h", $time, a, b); end end
module testbench;
   import dsoc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, rclk, rclk_oe_n, lck, lck_oe_n, pos, neg;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [9:0] rd, rd_oe_n, prev;
   logic [3:0] cnt = 4'h1;
   logic edge_exp = 1'b1;
   logic [32:0] rd_q[$];
   logic [9:0] w_q[$];
   logic [32:0] rd_exp;
   logic [9:0] w_exp;
   int mismatches = 0;
   int n_compared = 0;
   // 20 MHz, also the lock logic reference
   always #25 clk_in = ~clk_in;
   dsoc_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_input_pos_in(pos),
      .serial_input_neg_in(neg), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(addr), .pwdata_in(wdat), .prdata_out(rdat), .pready_out(rdy),
      .pslverr_out(err), .recovered_data_out(rd), .recovered_data_oe_n_out(rd_oe_n),
      .recovered_clock_out(rclk), .recovered_clock_oe_n_out(rclk_oe_n),
      .lock_n_out(lck), .lock_n_oe_n_out(lck_oe_n));
   dsoc_ser_model i_ser (.clk_in(clk_in), .pos_out(pos), .neg_out(neg));
   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (psel && pen && rdy && !pwr && rd_q.size() > 0) begin
         rd_exp = rd_q.pop_front();
         `CHK({err, rdat}, rd_exp)
      end
      if (!rd_oe_n[0] && rd !== prev && w_q.size() > 0) begin
         w_exp = w_q.pop_front();
         `CHK(rd, w_exp)
         `CHK(rclk, edge_exp)
      end
      prev <= rd;
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= wr;
      addr <= a;
      wdat <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (rdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // untracked frames carry zero words, only to gain lock
   task automatic tx(input int n, input logic track);
      logic [9:0] w;
      for (int i = 0; i < n; i++) begin
         w = track ? {6'($urandom()), cnt} : 10'h000;
         cnt++;
         i_ser.send(w);
         if (track) w_q.push_back(w);
      end
      while (i_ser.q.size() != 0) @(posedge clk_in);
      repeat (8) @(posedge clk_in);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_in);
      mismatches++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h2F2C));
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      `CHK({lck, lck_oe_n, rclk_oe_n, rd_oe_n}, 13'h1FFF)
      rdchk(DSOC_STAT_OFFS, 33'h3);
      rdchk(DSOC_CTRL_OFFS, 33'h0);
      apb(1'b1, 8'h10, 32'h7);
      rdchk(8'h10, 33'h100000000);
      apb(1'b1, DSOC_CTRL_OFFS, 32'h1);
      tx(1, 1'b0);
      `CHK({lck, lck_oe_n}, 2'b10)
      tx(3, 1'b0);
      `CHK({lck, lck_oe_n, rd_oe_n[0]}, 3'b001)
      apb(1'b1, DSOC_CTRL_OFFS, 32'h5);
      tx(9, 1'b1);
      void'(w_q.pop_back());
      rdchk(DSOC_STAT_OFFS, 33'hC);
      apb(1'b1, DSOC_STAT_OFFS, 32'h8);
      rdchk(DSOC_STAT_OFFS, 33'h4);
      apb(1'b1, DSOC_CTRL_OFFS, 32'h7);
      repeat (40) @(posedge clk_in);
      `CHK(w_q.size() == 0, 1'b1)
      rdchk(DSOC_STAT_OFFS, 33'h2);
      edge_exp = 1'b0;
      apb(1'b1, DSOC_CTRL_OFFS, 32'h3);
      tx(3, 1'b1);
      `CHK(w_q.size() == 0, 1'b1)
      apb(1'b1, DSOC_CTRL_OFFS, 32'h2);
      repeat (3) @(posedge clk_in);
      `CHK({lck_oe_n, rclk_oe_n, rd_oe_n}, 12'hFFF)
      complete_run();
   end
endmodule
bind dsoc_top dsoc_monitor #(.WORD_W(WORD_W)) i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .recovered_data_out(recovered_data_out),
   .recovered_data_oe_n_out(recovered_data_oe_n_out), .recovered_clock_out(recovered_clock_out),
   .recovered_clock_oe_n_out(recovered_clock_oe_n_out), .lock_n_out(lock_n_out),
   .lock_n_oe_n_out(lock_n_oe_n_out));
`default_nettype wire
